// ===== logic/sac_defines.svh
// timing counts and field constants for the converter sequencer
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_CLK_NS          20
`define SAC_WORD_BITS       18
`define SAC_FIFO_DEPTH      16
`define SAC_CEIL(ns)        (((ns) + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_FLOOR(ns)       ((ns) / `SAC_CLK_NS)
`define SAC_START_BUSY_NS   35
`define SAC_START_BUSY_CYC  `SAC_FLOOR(`SAC_START_BUSY_NS)
`define SAC_CONV_NS         1300
`define SAC_CONV_CYC        `SAC_FLOOR(`SAC_CONV_NS)
`define SAC_BUSY_MAX_NS     1500
`define SAC_BUSY_MAX_CYC    `SAC_FLOOR(`SAC_BUSY_MAX_NS)
`define SAC_DATA_BUSY_NS    20
`define SAC_DATA_BUSY_CYC   `SAC_CEIL(`SAC_DATA_BUSY_NS)
`define SAC_EOC_BUSY_NS     10
`define SAC_EOC_BUSY_CYC    `SAC_CEIL(`SAC_EOC_BUSY_NS)
`define SAC_SYNC_BUSY_NS    25
`define SAC_SYNC_BUSY_CYC   `SAC_CEIL(`SAC_SYNC_BUSY_NS)
`define SAC_LEAD0_NS        3
`define SAC_LEADN_NS        17
`define SAC_HI0_NS          12
`define SAC_HI1_NS          22
`define SAC_HI2_NS          50
`define SAC_HI3_NS          100
`define SAC_PER0_NS         25
`define SAC_PER1_NS         60
`define SAC_PER2_NS         120
`define SAC_PER3_NS         240
`define SAC_TAIL0_NS        3
`define SAC_TAIL1_NS        60
`define SAC_TAIL2_NS        140
`define SAC_TAIL3_NS        300
`define SAC_RA_BUSY0_NS     2250
`define SAC_RA_BUSY1_NS     3000
`define SAC_RA_BUSY2_NS     4500
`define SAC_RA_BUSY3_NS     7500
`define SAC_HALF(hi, per)   ((`SAC_CEIL(hi) > `SAC_CEIL((per) / 2)) ? \
                              `SAC_CEIL(hi) : `SAC_CEIL(((per) + 1) / 2))
`endif

// ===== logic/sac_pkg.sv
// types shared by the converter sequencer
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_MODE_PAR    = 2'h0,
    SAC_MODE_SER_RD = 2'h1,
    SAC_MODE_SER_RA = 2'h2,
    SAC_MODE_PAR_B  = 2'h3
  } sac_mode_t;
  typedef enum logic [1:0] {C_IDLE, C_CONV, C_PUSH, C_WAIT} sac_conv_state_t;
  typedef enum logic [2:0] {
    O_IDLE, O_SETTLE, O_LEAD, O_HIGH, O_LOW, O_TAIL, O_BTAIL
  } sac_out_state_t;
endpackage : sac_pkg

// ===== logic/sac_fifo.sv
// result fifo between conversion core and output engine
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  always_comb begin
    in_ready_o  = (cnt_reg != DEPTH[AW:0]);
    out_valid_o = (cnt_reg != '0);
    out_data_o  = mem[rd_reg];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_next     = push ? wr_reg + 1'b1 : wr_reg;
    rd_next     = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next    = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // storage has no reset; content is only read when counted valid
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : sac_fifo

// ===== logic/sac_adc_seq.sv
// conversion sequencing and result readout of the sar converter
`timescale 1ns/1ps
`include "sac_defines.svh"

// Overview of operation
// - busy rises within 35 ns of conversion start falling.
// - busy stays at most 1.5 us except master read-after-convert.
// - busy falls at least 10 ns after conversion completes.
// - parallel modes present valid data within 1.5 us of start.
// - parallel data is valid at least 20 ns before busy falls.
// - each result readable right after its own conversion, no pipeline.
// - every result is an 18-bit word, parallel or serial.
// - read-during-convert serial clock period 25 to 40 ns, any divider.
// - read-after-convert divider picks clock period per setting.
// - read-after-convert clock high and low minimums per setting.
// - first serial clock edge waits 3 or 17 ns after frame sync.
// - frame sync held 3, 60, 140 or 300 ns after last edge.
// - read-after-convert busy at most 2.25, 3, 4.5 or 7.5 us.
// - read-after-convert frame sync rises once conversion finished.
// - read-after busy falls two cycles (40 ns) after frame sync falls.
module sac_adc_seq (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      conversion_start_n_i,
  input  wire logic [1:0]                output_mode_i,
  input  wire logic [1:0]                shift_clock_divider_i,
  input  wire logic [`SAC_WORD_BITS-1:0] sample_code_i,
  output logic                           busy_o,
  output logic      [`SAC_WORD_BITS-1:0] parallel_data_o,
  output logic                           frame_sync_o,
  output logic                           shift_clk_o,
  output logic                           serial_result_out_o
);
  import sac_pkg::*;
  localparam int W = `SAC_WORD_BITS;
  localparam int BUSY_MAX = `SAC_BUSY_MAX_CYC;

  function automatic logic is_serial(input logic [1:0] m);
    return (m == SAC_MODE_SER_RD) || (m == SAC_MODE_SER_RA);
  endfunction : is_serial

  function automatic logic [4:0] half_cyc(input logic [1:0] d);
    unique case (d)
      2'h0: half_cyc = 5'(`SAC_HALF(`SAC_HI0_NS, `SAC_PER0_NS));
      2'h1: half_cyc = 5'(`SAC_HALF(`SAC_HI1_NS, `SAC_PER1_NS));
      2'h2: half_cyc = 5'(`SAC_HALF(`SAC_HI2_NS, `SAC_PER2_NS));
      2'h3: half_cyc = 5'(`SAC_HALF(`SAC_HI3_NS, `SAC_PER3_NS));
    endcase
  endfunction : half_cyc

  function automatic logic [4:0] tail_cyc(input logic [1:0] d);
    unique case (d)
      2'h0: tail_cyc = 5'(`SAC_CEIL(`SAC_TAIL0_NS));
      2'h1: tail_cyc = 5'(`SAC_CEIL(`SAC_TAIL1_NS));
      2'h2: tail_cyc = 5'(`SAC_CEIL(`SAC_TAIL2_NS));
      2'h3: tail_cyc = 5'(`SAC_CEIL(`SAC_TAIL3_NS));
    endcase
  endfunction : tail_cyc

  // mode and divider straps are pins: two flops before use
  logic [1:0] mode_s1_reg, mode_s2_reg, div_s1_reg, div_s2_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      div_s1_reg  <= 2'h0;
      div_s2_reg  <= 2'h0;
    end else begin
      mode_s1_reg <= output_mode_i;
      mode_s2_reg <= mode_s1_reg;
      div_s1_reg  <= shift_clock_divider_i;
      div_s2_reg  <= div_s1_reg;
    end
  end

  // start comes from host logic on this clock; a synchroniser here
  // would cost the 35 ns busy response
  logic start_d_reg, start_fall;
  assign start_fall = start_d_reg && !conversion_start_n_i;

  sac_conv_state_t  cst_reg, cst_next;
  logic [6:0]       ccnt_reg, ccnt_next;
  logic             busy_reg, busy_next;
  logic             fifo_in_valid, fifo_in_ready;
  logic             fifo_out_valid, fifo_out_ready;
  logic [W-1:0]     fifo_out_data;
  logic             out_done, eoc;

  always_comb begin
    cst_next      = cst_reg;
    ccnt_next     = ccnt_reg;
    busy_next     = busy_reg;
    fifo_in_valid = 1'b0;
    eoc           = 1'b0;
    unique case (cst_reg)
      C_IDLE: begin
        // starts while busy are not taken
        if (start_fall) begin
          busy_next = 1'b1;
          ccnt_next = 7'(`SAC_CONV_CYC - 1);
          cst_next  = C_CONV;
        end
      end
      C_CONV: begin
        if (ccnt_reg == 7'h00) begin
          cst_next = C_PUSH;
        end else begin
          ccnt_next = ccnt_reg - 7'h01;
        end
      end
      C_PUSH: begin
        // full fifo stalls the end of conversion, busy stays high
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          eoc      = 1'b1;
          cst_next = C_WAIT;
        end
      end
      C_WAIT: begin
        if (out_done) begin
          busy_next = 1'b0;
          cst_next  = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_d_reg <= 1'b1;
      cst_reg     <= C_IDLE;
      ccnt_reg    <= 7'h00;
      busy_reg    <= 1'b0;
    end else begin
      start_d_reg <= conversion_start_n_i;
      cst_reg     <= cst_next;
      ccnt_reg    <= ccnt_next;
      busy_reg    <= busy_next;
    end
  end
  assign busy_o = busy_reg;

  // fresh sample goes straight in; fall-through read keeps latency nil
  sac_fifo #(
    .WIDTH (W),
    .DEPTH (`SAC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sample_code_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  sac_out_state_t ost_reg, ost_next;
  logic [4:0]   ocnt_reg, ocnt_next, bits_reg, bits_next;
  logic [1:0]   odiv_reg, odiv_next;
  logic         ra_reg, ra_next;
  logic [W-1:0] par_reg, par_next, sh_reg, sh_next;
  logic         sync_reg, sync_next, sclk_reg, sclk_next;

  always_comb begin
    ost_next       = ost_reg;
    ocnt_next      = ocnt_reg;
    bits_next      = bits_reg;
    odiv_next      = odiv_reg;
    ra_next        = ra_reg;
    par_next       = par_reg;
    sh_next        = sh_reg;
    sync_next      = sync_reg;
    sclk_next      = sclk_reg;
    fifo_out_ready = 1'b0;
    out_done       = 1'b0;
    unique case (ost_reg)
      O_IDLE: begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid) begin
          if (is_serial(mode_s2_reg)) begin
            ra_next   = (mode_s2_reg == SAC_MODE_SER_RA);
            // read-during always runs the fastest clock
            odiv_next = ra_next ? div_s2_reg : 2'h0;
            sh_next   = fifo_out_data;
            bits_next = 5'(W);
            sync_next = 1'b1;
            ocnt_next = (odiv_next == 2'h0) ?
                        5'(`SAC_CEIL(`SAC_LEAD0_NS)) :
                        5'(`SAC_CEIL(`SAC_LEADN_NS));
            ost_next  = O_LEAD;
          end else begin
            par_next = fifo_out_data;
            ost_next = O_SETTLE;
          end
        end
      end
      O_SETTLE: begin
        out_done = 1'b1;
        ost_next = O_IDLE;
      end
      O_LEAD: begin
        // read-during frees busy now; the word shifts under next convert
        if (!ra_reg && ocnt_reg == 5'(`SAC_CEIL(`SAC_LEAD0_NS))) begin
          out_done = 1'b1;
        end
        if (ocnt_reg == 5'h01) begin
          sclk_next = 1'b1;
          ocnt_next = half_cyc(odiv_reg);
          ost_next  = O_HIGH;
        end else begin
          ocnt_next = ocnt_reg - 5'h01;
        end
      end
      O_HIGH: begin
        if (ocnt_reg == 5'h01) begin
          sclk_next = 1'b0;
          bits_next = bits_reg - 5'h01;
          if (bits_reg == 5'h01) begin
            ocnt_next = tail_cyc(odiv_reg);
            ost_next  = O_TAIL;
          end else begin
            sh_next   = {sh_reg[W-2:0], 1'b0};
            ocnt_next = half_cyc(odiv_reg);
            ost_next  = O_LOW;
          end
        end else begin
          ocnt_next = ocnt_reg - 5'h01;
        end
      end
      O_LOW: begin
        if (ocnt_reg == 5'h01) begin
          sclk_next = 1'b1;
          ocnt_next = half_cyc(odiv_reg);
          ost_next  = O_HIGH;
        end else begin
          ocnt_next = ocnt_reg - 5'h01;
        end
      end
      O_TAIL: begin
        if (ocnt_reg == 5'h01) begin
          sync_next = 1'b0;
          ocnt_next = 5'(`SAC_SYNC_BUSY_CYC);
          ost_next  = ra_reg ? O_BTAIL : O_IDLE;
        end else begin
          ocnt_next = ocnt_reg - 5'h01;
        end
      end
      O_BTAIL: begin
        // busy covers the whole transfer in read-after
        if (ocnt_reg == 5'h01) begin
          out_done = 1'b1;
          ost_next = O_IDLE;
        end else begin
          ocnt_next = ocnt_reg - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ost_reg  <= O_IDLE;
      ocnt_reg <= 5'h00;
      bits_reg <= 5'h00;
      odiv_reg <= 2'h0;
      ra_reg   <= 1'b0;
      par_reg  <= '0;
      sh_reg   <= '0;
      sync_reg <= 1'b0;
      sclk_reg <= 1'b0;
    end else begin
      ost_reg  <= ost_next;
      ocnt_reg <= ocnt_next;
      bits_reg <= bits_next;
      odiv_reg <= odiv_next;
      ra_reg   <= ra_next;
      par_reg  <= par_next;
      sh_reg   <= sh_next;
      sync_reg <= sync_next;
      sclk_reg <= sclk_next;
    end
  end
  assign parallel_data_o     = par_reg;
  assign frame_sync_o        = sync_reg;
  assign shift_clk_o         = sclk_reg;
  assign serial_result_out_o = sh_reg[W-1];

  // helper counters read only by the checks below
  logic [9:0] bcnt_reg, hcnt_reg;
  logic [4:0] ecnt_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bcnt_reg <= 10'h000;
      hcnt_reg <= 10'h000;
      ecnt_reg <= 5'h00;
    end else begin
      bcnt_reg <= busy_reg ? bcnt_reg + 10'h001 : 10'h000;
      hcnt_reg <= sclk_reg ? hcnt_reg + 10'h001 : 10'h000;
      ecnt_reg <= !sync_reg ? 5'h00 :
                  (sclk_next && !sclk_reg) ? ecnt_reg + 5'h01 : ecnt_reg;
    end
  end

  sequence s_accept;
    cst_reg == C_IDLE && start_fall;
  endsequence
  sequence s_sync_end;
    sync_reg ##1 !sync_reg;
  endsequence

  property p_busy_rise;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_accept |=> busy_o;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise after start");

  property p_busy_max;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    // read-after keeps busy through the whole frame, tail included
    busy_o && !(ra_reg && ost_reg != O_IDLE) && cst_reg != C_PUSH
      |-> bcnt_reg <= 10'(BUSY_MAX);
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy high too long");

  property p_eoc_busy;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    eoc |=> busy_o;
  endproperty
  a_eoc_busy: assert property (p_eoc_busy)
    else $error("busy fell with end of conversion");

  property p_par_setup;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ost_reg == O_SETTLE |-> busy_o ##1 !busy_o;
  endproperty
  a_par_setup: assert property (p_par_setup)
    else $error("parallel data not ahead of busy fall");

  property p_par_in_time;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ost_reg == O_SETTLE |-> bcnt_reg <= 10'(BUSY_MAX);
  endproperty
  a_par_in_time: assert property (p_par_in_time)
    else $error("parallel data late");

  property p_word_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_sync_end |-> ecnt_reg == 5'(W) && $past(ecnt_reg) == 5'(W);
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("serial word not 18 bits");

  property p_high_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(sclk_reg) |-> hcnt_reg == 10'(half_cyc(odiv_reg));
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("serial clock high phase wrong");

  property p_rd_fast;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(sclk_reg) && !ra_reg |=> !sclk_reg ##1 sclk_reg || !sync_reg;
  endproperty
  a_rd_fast: assert property (p_rd_fast)
    else $error("read-during clock period wrong");

  property p_lead;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(sync_reg) |-> !sclk_reg;
  endproperty
  a_lead: assert property (p_lead)
    else $error("clock edge with frame sync");

  property p_sync_busy;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_sync_end ##0 ra_reg |-> busy_o ##1 busy_o ##1 !busy_o;
  endproperty
  a_sync_busy: assert property (p_sync_busy)
    else $error("busy not low two cycles after sync");

  property p_ra_busy;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    busy_o && ra_reg |-> bcnt_reg <= 10'(`SAC_FLOOR(`SAC_RA_BUSY3_NS));
  endproperty
  a_ra_busy: assert property (p_ra_busy)
    else $error("read-after busy too long");
endmodule : sac_adc_seq

// ===== sim/sac_host_model.sv
// host model: paces conversion starts and collects both result ports
`timescale 1ns/1ps
module sac_host_model #(
  parameter int W = 18
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         go_i,
  input  wire logic         busy_i,
  input  wire logic         sync_i,
  input  wire logic         sclk_i,
  input  wire logic         sdo_i,
  input  wire logic [W-1:0] pdata_i,
  output logic              conversion_start_n_o,
  output logic      [W-1:0] par_word_o,
  output logic      [W-1:0] ser_word_o,
  output logic      [4:0]   ser_bits_o
);
  // 1.75 us at 20 ns, rounded up so the spacing is never short
  localparam int GAP_CYC = 88;
  logic [7:0] gap_reg;
  logic       busy_d_reg;
  logic       sync_d_reg;
  logic       sclk_d_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conversion_start_n_o <= 1'b1;
      gap_reg              <= 8'h00;
      busy_d_reg           <= 1'b0;
      sync_d_reg           <= 1'b0;
      sclk_d_reg           <= 1'b0;
      par_word_o           <= '0;
      ser_word_o           <= '0;
      ser_bits_o           <= 5'h00;
    end else begin
      busy_d_reg           <= busy_i;
      sync_d_reg           <= sync_i;
      sclk_d_reg           <= sclk_i;
      conversion_start_n_o <= 1'b1;
      if (gap_reg != 8'h00) begin
        gap_reg <= gap_reg - 8'h01;
      end
      // one-cycle low pulse, never while busy
      if (go_i && !busy_i && conversion_start_n_o
          && gap_reg == 8'h00) begin
        conversion_start_n_o <= 1'b0;
        gap_reg              <= 8'(GAP_CYC - 1);
      end
      // word taken only once busy has dropped
      if (busy_d_reg && !busy_i) begin
        par_word_o <= pdata_i;
      end
      if (sync_i && !sync_d_reg) begin
        ser_bits_o <= 5'h00;
      end
      if (sync_i && sclk_i && !sclk_d_reg) begin
        ser_word_o <= {ser_word_o[W-2:0], sdo_i};
        ser_bits_o <= ser_bits_o + 5'h01;
      end
    end
  end
endmodule : sac_host_model

// ===== sim/tb.sv
// self-checking bench for the converter sequencer and its result fifo
`timescale 1ns/1ps
`include "sac_defines.svh"
module tb;
  import sac_pkg::*;
  localparam int W = `SAC_WORD_BITS;
  localparam int BR = 0, BF = 1, SR = 2, SF = 3, R1 = 4, LF = 5, DV = 6;
  localparam int LDN [4] = '{3, 17, 17, 17};
  localparam int PLO [4] = '{25, 60, 120, 240};
  localparam int PHI [4] = '{40, 80, 160, 320};
  localparam int HNS [4] = '{12, 22, 50, 100};
  localparam int LNS [4] = '{7, 21, 49, 99};
  localparam int TNS [4] = '{3, 60, 140, 300};
  localparam int BNS [4] = '{2250, 3000, 4500, 7500};
  logic         ref_clk = 1'b0;
  logic         rst_n   = 1'b0;
  logic         go      = 1'b0;
  logic [1:0]   mode    = SAC_MODE_PAR;
  logic [1:0]   div     = 2'h0;
  logic [W-1:0] code    = '0;
  logic         busy, fsync, sclk, sdo, start_n;
  logic [W-1:0] pdata, par_word, ser_word;
  logic [4:0]   ser_bits;
  int           n_errors = 0;
  int           samples_checked = 0;
  int           tm [7];
  int           hmin, lmin, pmin, pmax;

  always #10 ref_clk = ~ref_clk;

  sac_adc_seq dut_u (
    .ref_clk_i            (ref_clk),
    .rst_n_i              (rst_n),
    .conversion_start_n_i (start_n),
    .output_mode_i        (mode),
    .shift_clock_divider_i(div),
    .sample_code_i        (code),
    .busy_o               (busy),
    .parallel_data_o      (pdata),
    .frame_sync_o         (fsync),
    .shift_clk_o          (sclk),
    .serial_result_out_o  (sdo)
  );
  sac_host_model #(.W(W)) host_u (
    .ref_clk_i           (ref_clk),
    .rst_n_i             (rst_n),
    .go_i                (go),
    .busy_i              (busy),
    .sync_i              (fsync),
    .sclk_i              (sclk),
    .sdo_i               (sdo),
    .pdata_i             (pdata),
    .conversion_start_n_o(start_n),
    .par_word_o          (par_word),
    .ser_word_o          (ser_word),
    .ser_bits_o          (ser_bits)
  );
  task automatic check_word(string nm, logic [W-1:0] e, logic [W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic check_rng(string nm, int lo, int hi, int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask : check_rng

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one conversion; event times in cycles after start is seen low
  task automatic run_conv();
    int   n;
    int   hc;
    int   lc;
    int   lr;
    logic sp;
    logic bp;
    logic cp;
    foreach (tm[i]) tm[i] = -1;
    hc = 0;
    lc = 0;
    lr = 0;
    hmin = 999;
    lmin = 999;
    pmin = 999;
    pmax = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    for (n = 0; n < 200 && start_n !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    sp = fsync;
    bp = busy;
    cp = sclk;
    for (n = 0; n < 800; n++) begin
      if (busy && tm[BR] < 0) tm[BR] = n;
      if (!busy && bp) tm[BF] = n;
      if (fsync && !sp) tm[SR] = n;
      if (!fsync && sp) tm[SF] = n;
      if (pdata === code && tm[DV] < 0) tm[DV] = n;
      if (sclk && !cp) begin
        if (tm[R1] >= 0) begin
          pmin = (n - lr < pmin) ? n - lr : pmin;
          pmax = (n - lr > pmax) ? n - lr : pmax;
          lmin = (lc < lmin) ? lc : lmin;
        end else begin
          tm[R1] = n;
        end
        lr = n;
        hc = 0;
      end
      if (!sclk && cp) begin
        tm[LF] = n;
        hmin = (hc < hmin) ? hc : hmin;
        lc = 0;
      end
      if (sclk) hc++;
      else lc++;
      // modes 0 and 3 are parallel: no frame to wait for
      if (tm[BF] >= 0 && (tm[SF] >= 0 || mode[0] == mode[1])) break;
      sp = fsync;
      bp = busy;
      cp = sclk;
      @(posedge ref_clk);
      go <= 1'b0;
      #1;
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : run_conv

  task automatic t_par(logic [1:0] m, logic [W-1:0] c);
    @(posedge ref_clk);
    mode <= m;
    code <= c;
    repeat (3) @(posedge ref_clk);
    run_conv();
    check_rng("busy_rise", 1, 1, tm[BR]);
    check_rng("busy_ns", 1, 1500, (tm[BF] - tm[BR]) * 20);
    check_rng("busy_conv", `SAC_CONV_CYC + 1, 999, tm[BF] - tm[BR]);
    check_rng("data_ns", 0, 1500, tm[DV] * 20);
    check_rng("data_lead", 1, 999, tm[BF] - tm[DV]);
    check_word("par_word", c, par_word);
  endtask : t_par

  task automatic t_ser_ra(logic [1:0] d, logic [W-1:0] c);
    @(posedge ref_clk);
    mode <= SAC_MODE_SER_RA;
    div  <= d;
    code <= c;
    repeat (3) @(posedge ref_clk);
    run_conv();
    check_rng("busy_rise", 1, 1, tm[BR]);
    check_rng("sync_rise", `SAC_CONV_CYC + 1, 75, tm[SR]);
    check_rng("lead_ns", LDN[d], 999, (tm[R1] - tm[SR]) * 20);
    check_rng("per_min", PLO[d], PHI[d], pmin * 20);
    check_rng("per_max", PLO[d], PHI[d], pmax * 20);
    check_rng("high_ns", HNS[d], 9999, hmin * 20);
    check_rng("low_ns", LNS[d], 9999, lmin * 20);
    check_rng("tail_ns", TNS[d], 9999, (tm[SF] - tm[LF]) * 20);
    check_rng("busy_ns", 1, BNS[d], (tm[BF] - tm[BR]) * 20);
    check_rng("sync_busy", 2, 2, tm[BF] - tm[SF]);
    check_rng("ser_bits", W, W, int'(ser_bits));
    check_word("ser_word", c, ser_word);
  endtask : t_ser_ra

  task automatic t_ser_rd(logic [1:0] d, logic [W-1:0] c);
    @(posedge ref_clk);
    mode <= SAC_MODE_SER_RD;
    div  <= d;
    code <= c;
    repeat (3) @(posedge ref_clk);
    run_conv();
    check_rng("busy_ns", 1, 1500, (tm[BF] - tm[BR]) * 20);
    check_rng("per_min", 25, 40, pmin * 20);
    check_rng("per_max", 25, 40, pmax * 20);
    check_rng("high_ns", 12, 9999, hmin * 20);
    check_rng("low_ns", 7, 9999, lmin * 20);
    check_word("ser_word", c, ser_word);
  endtask : t_ser_rd

  // two frames in a row through the result queue: each word its own
  task automatic t_fifo(logic [W-1:0] c0, logic [W-1:0] c1);
    logic [W-1:0] held;
    @(posedge ref_clk);
    mode <= SAC_MODE_SER_RD;
    code <= c0;
    repeat (3) @(posedge ref_clk);
    held = pdata;
    run_conv();
    check_word("fifo_data0", c0, ser_word);
    @(posedge ref_clk);
    code <= c1;
    run_conv();
    check_word("fifo_data1", c1, ser_word);
    check_rng("fifo_bits", W, W, int'(ser_bits));
    check_word("par_hold", held, pdata);
  endtask : t_fifo

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_par(SAC_MODE_PAR, 18'h3FFFF);
    t_par(SAC_MODE_PAR_B, 18'h00001);
    t_par(SAC_MODE_PAR, 18'h2AAAA);
    t_fifo(18'h0F0F3, 18'h30C3C);
    t_ser_ra(2'h0, 18'h3C0F1);
    t_ser_ra(2'h1, 18'h15555);
    t_ser_ra(2'h2, 18'h20001);
    t_ser_ra(2'h3, 18'h3FFFE);
    t_ser_rd(2'h3, 18'h25A5C);
    t_ser_rd(2'h0, 18'h1C3F0);
    report_and_stop();
  end

  // about nine conversions of at most 400 cycles each, plus the fifo
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule : tb
